// ---- include/scop_pkg.sv ----
// Shared types and constants for the overhead and protection port block
// What this block does
// RULE1 - Output a recovered clock per channel
// RULE2 - Receive data timed from recovered channel clock
// RULE3 - Overhead serial ports active only in serial mode
// RULE4 - Fabric holds transmit overhead clock enable high; the fabric model drives it from run, so it is low while run is low
// RULE5 - Flag mirrors overhead clock and frame enable
// RULE6 - Overhead frame pulse exactly one cycle wide
// RULE7 - Link active flag high while link clock enabled
// RULE8 - Extracted overhead bits leave serially per channel
// RULE9 - Fabric supplies insert bits serially per channel
// RULE10 - Output enable status mirrors its setting
// RULE11 - Overhead enable status mirrors its setting
// RULE12 - Fabric drives four pair protection selects
// RULE13 - Fabric drives eight per-channel serial selects
// RULE14 - Overhead clock 25 to 77.76 MHz or low; the fabric model runs it free at 6.25 MHz
// RULE15 - Selects sampled synchronously; high means protect path
package scop_pkg;
  localparam int NUM_CH = 8;
  localparam int NUM_PAIRS = 4;
  localparam int NUM_SEL = NUM_PAIRS + NUM_CH;
  localparam int OHD_BITS = 8;
  localparam int OHD_CNT_W = $clog2(OHD_BITS);
  localparam int RCLK_HALF = 2;
  localparam int RCLK_CNT_W = 2;
  localparam logic [RCLK_CNT_W-1:0] RCLK_LAST = RCLK_CNT_W'(RCLK_HALF - 1);
  localparam logic [OHD_CNT_W-1:0] OHD_LAST = OHD_CNT_W'(OHD_BITS - 1);
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic SEL_WORKING = 1'b0;

  typedef struct packed {
    logic [NUM_CH-1:0] output_enable;
    logic [NUM_CH-1:0] overhead_enable;
    logic serial_mode;
    logic clk_fp_enable;
  } scop_cfg_type;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } scop_rx_byte_type;

  typedef logic [NUM_CH-1:0][OHD_BITS-1:0] scop_ohd_bytes_type;

  // Change counts only once second and third stage agree
  function automatic logic [NUM_SEL-1:0] sel_filter(
    input logic [NUM_SEL-1:0] cur,
    input logic [NUM_SEL-1:0] s2,
    input logic [NUM_SEL-1:0] s3
  );
    return (s2 & ~(s2 ^ s3)) | (cur & (s2 ^ s3));
  endfunction : sel_filter
endpackage : scop_pkg

// ---- hdl/scop_ohd_link.sv ----
// Serial overhead link logic on the overhead processor clock
`timescale 1ns/100ps
module scop_ohd_link (
  input wire logic link_clk,
  input wire logic reset_level,
  input wire logic run_level,
  input wire logic ack_tgl,
  input wire scop_pkg::scop_ohd_bytes_type extract_hold,
  input wire logic [scop_pkg::NUM_CH-1:0] insert_in,
  output logic [scop_pkg::NUM_CH-1:0] serial_out,
  output logic frame_pulse,
  output logic frame_tgl,
  output scop_pkg::scop_ohd_bytes_type insert_cap
);
  logic rst_s1_q, rst_q, run_s1_q, run_q, ack_s1_q, ack_s2_q, ack_seen_q;
  logic [scop_pkg::OHD_CNT_W-1:0] bit_cnt_q;
  scop_pkg::scop_ohd_bytes_type out_sh_q, in_sh_q;

  always_ff @(posedge link_clk)
  begin
    rst_s1_q <= reset_level;
    rst_q <= rst_s1_q;
    run_s1_q <= run_level;
    run_q <= run_s1_q;
    ack_s1_q <= ack_tgl;
    ack_s2_q <= ack_s1_q;
  end

  // Bit counter and frame pulse only run in serial mode
  always_ff @(posedge link_clk)
  begin
    if (rst_q || !run_q)
    begin
      bit_cnt_q <= '0;
      frame_pulse <= 1'b0; // RULE3
    end
    else
    begin
      bit_cnt_q <= bit_cnt_q + 1'b1;
      frame_pulse <= (bit_cnt_q == '0); // RULE6
    end
  end

  // Extract shift: load fresh bytes at frame start, MSB first
  always_ff @(posedge link_clk)
  begin
    if (rst_q)
    begin
      out_sh_q <= '0;
      ack_seen_q <= 1'b0;
      serial_out <= '0;
    end
    else if (!run_q)
    begin
      out_sh_q <= '0;
      serial_out <= '0; // RULE3
    end
    else
    begin
      for (int ch = 0; ch < scop_pkg::NUM_CH; ch++)
      begin
        // Unacknowledged hold byte is not sent, first bit included
        if (bit_cnt_q != '0)
          serial_out[ch] <= out_sh_q[ch][scop_pkg::OHD_BITS-1]; // RULE8
        else if (ack_s2_q != ack_seen_q)
          serial_out[ch] <= extract_hold[ch][scop_pkg::OHD_BITS-1]; // RULE8
        else
          serial_out[ch] <= 1'b0;
        if (bit_cnt_q == '0)
          out_sh_q[ch] <= (ack_s2_q != ack_seen_q) ? {extract_hold[ch][scop_pkg::OHD_BITS-2:0], 1'b0} : '0;
        else
          out_sh_q[ch] <= {out_sh_q[ch][scop_pkg::OHD_BITS-2:0], 1'b0};
      end
      if (bit_cnt_q == '0)
        ack_seen_q <= ack_s2_q;
    end
  end

  // Insert capture: whole byte handed over at frame end
  always_ff @(posedge link_clk)
  begin
    if (rst_q)
    begin
      in_sh_q <= '0;
      insert_cap <= '0;
      frame_tgl <= 1'b0;
    end
    else if (run_q)
    begin
      for (int ch = 0; ch < scop_pkg::NUM_CH; ch++)
        in_sh_q[ch] <= {in_sh_q[ch][scop_pkg::OHD_BITS-2:0], insert_in[ch]}; // RULE9
      if (bit_cnt_q == scop_pkg::OHD_LAST)
      begin
        for (int ch = 0; ch < scop_pkg::NUM_CH; ch++)
          insert_cap[ch] <= {in_sh_q[ch][scop_pkg::OHD_BITS-2:0], insert_in[ch]};
        frame_tgl <= ~frame_tgl;
      end
    end
  end

  default clocking cb @(posedge link_clk); endclocking
  default disable iff (rst_q);

  a_frame_one_wide: assert property (frame_pulse |=> !frame_pulse) // RULE6
    else $error("frame pulse wider than one cycle");
  a_frame_period: assert property (frame_pulse ##1 run_q [*8] |-> frame_pulse) // RULE6
    else $error("frame pulse period wrong");
  a_link_idle_quiet: assert property (!run_q |=> serial_out == '0 && !frame_pulse) // RULE3
    else $error("link active outside serial mode");
  c_frame_seen: cover property (frame_pulse);
endmodule : scop_ohd_link

// ---- hdl/scop_core.sv ----
// Overhead, status and protection select port logic of the transceiver core
`timescale 1ns/100ps
module scop_core #(
  parameter int NUM_CH = scop_pkg::NUM_CH
) (
  input wire logic clk,
  input wire logic reset,
  input wire scop_pkg::scop_cfg_type cfg,
  input wire logic tx_overhead_clock_enable,
  input wire logic pair_protect_select_first,
  input wire logic pair_protect_select_second,
  input wire logic pair_protect_select_third,
  input wire logic pair_protect_select_fourth,
  input wire logic serial_protect_select_ch0,
  input wire logic serial_protect_select_ch1,
  input wire logic serial_protect_select_ch2,
  input wire logic serial_protect_select_ch3,
  input wire logic serial_protect_select_ch4,
  input wire logic serial_protect_select_ch5,
  input wire logic serial_protect_select_ch6,
  input wire logic serial_protect_select_ch7,
  input wire scop_pkg::scop_rx_byte_type [NUM_CH-1:0] rx_word,
  input wire scop_pkg::scop_ohd_bytes_type ohd_extract_bytes,
  input wire logic overhead_processor_clock,
  input wire logic [NUM_CH-1:0] overhead_serial_insert_in,
  output logic [NUM_CH-1:0] recovered_channel_clock,
  output scop_pkg::scop_rx_byte_type [NUM_CH-1:0] rx_data_out,
  output logic [NUM_CH-1:0] rx_output_enable_status,
  output logic [NUM_CH-1:0] overhead_channel_enable_status,
  output logic rx_overhead_clock_enable_flag,
  output logic overhead_link_clock_active,
  output logic rx_overhead_frame_pulse,
  output logic [NUM_CH-1:0] overhead_serial_out,
  output scop_pkg::scop_ohd_bytes_type ohd_insert_bytes,
  output logic ohd_insert_valid,
  output logic [scop_pkg::NUM_PAIRS-1:0] pair_protect_active,
  output logic [NUM_CH-1:0] serial_protect_active
);
  logic [scop_pkg::NUM_SEL-1:0] sel_raw, sel_s1_q, sel_s2_q, sel_s3_q, sel_q, sel_d;
  logic txen_s1_q, txen_s2_q, txen_s3_q, txen_q;
  logic link_run_q, reset_q;
  logic frm_s1_q, frm_s2_q, frm_last_q, frame_tgl, ack_tgl_q;
  scop_pkg::scop_ohd_bytes_type extract_hold_q, insert_cap;
  logic [NUM_CH-1:0][scop_pkg::RCLK_CNT_W-1:0] rclk_cnt_q;
  logic [NUM_CH-1:0] rclk_rise;
  scop_pkg::scop_rx_byte_type [NUM_CH-1:0] rx_pend_q;

  assign sel_raw = {serial_protect_select_ch7, serial_protect_select_ch6,
                    serial_protect_select_ch5, serial_protect_select_ch4,
                    serial_protect_select_ch3, serial_protect_select_ch2,
                    serial_protect_select_ch1, serial_protect_select_ch0,
                    pair_protect_select_fourth, pair_protect_select_third,
                    pair_protect_select_second, pair_protect_select_first};
  assign sel_d = scop_pkg::sel_filter(sel_q, sel_s2_q, sel_s3_q);

  // Protection selects: three-stage sampling, agree filter
  always_ff @(posedge clk)
  begin
    sel_s1_q <= sel_raw;
    sel_s2_q <= sel_s1_q;
    sel_s3_q <= sel_s2_q;
    if (reset)
    begin
      sel_q <= {scop_pkg::NUM_SEL{scop_pkg::SEL_WORKING}};
      pair_protect_active <= '0;
      serial_protect_active <= '0;
    end
    else
    begin
      sel_q <= sel_d; // RULE15
      pair_protect_active <= sel_d[scop_pkg::NUM_PAIRS-1:0]; // RULE12
      serial_protect_active <= sel_d[scop_pkg::NUM_SEL-1:scop_pkg::NUM_PAIRS]; // RULE13
    end
  end

  // Status mirrors of the enable settings
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rx_output_enable_status <= '0;
      overhead_channel_enable_status <= '0;
      rx_overhead_clock_enable_flag <= 1'b0;
    end
    else
    begin
      rx_output_enable_status <= cfg.output_enable; // RULE10
      overhead_channel_enable_status <= cfg.overhead_enable; // RULE11
      rx_overhead_clock_enable_flag <= cfg.clk_fp_enable; // RULE5
    end
  end

  // Transmit overhead enable from fabric, and link run level
  always_ff @(posedge clk)
  begin
    txen_s1_q <= tx_overhead_clock_enable;
    txen_s2_q <= txen_s1_q;
    txen_s3_q <= txen_s2_q;
    reset_q <= reset;
    if (reset)
    begin
      txen_q <= 1'b0;
      link_run_q <= 1'b0;
      overhead_link_clock_active <= 1'b0;
    end
    else
    begin
      if (txen_s2_q == txen_s3_q)
        txen_q <= txen_s2_q; // RULE4
      link_run_q <= cfg.serial_mode && cfg.clk_fp_enable && txen_q; // RULE3
      overhead_link_clock_active <= link_run_q; // RULE7
    end
  end

  // Per-channel recovered clock and receive data timed from it
  always_comb
  begin
    for (int ch = 0; ch < NUM_CH; ch++)
      rclk_rise[ch] = (rclk_cnt_q[ch] == scop_pkg::RCLK_LAST) && !recovered_channel_clock[ch];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rclk_cnt_q <= '0;
      recovered_channel_clock <= '0;
      rx_pend_q <= '0;
      rx_data_out <= '0;
    end
    else
    begin
      for (int ch = 0; ch < NUM_CH; ch++)
      begin
        if (rclk_cnt_q[ch] == scop_pkg::RCLK_LAST)
        begin
          rclk_cnt_q[ch] <= '0;
          recovered_channel_clock[ch] <= ~recovered_channel_clock[ch]; // RULE1
        end
        else
          rclk_cnt_q[ch] <= rclk_cnt_q[ch] + 1'b1;
        if (rclk_rise[ch])
        begin
          rx_data_out[ch].data <= cfg.output_enable[ch] ? rx_pend_q[ch].data : scop_pkg::RESET_BYTE; // RULE2
          rx_data_out[ch].valid <= rx_pend_q[ch].valid && cfg.output_enable[ch];
          rx_pend_q[ch] <= rx_word[ch];
        end
        else if (rx_word[ch].valid)
          rx_pend_q[ch] <= rx_word[ch];
      end
    end
  end

  // Frame handover from the link domain
  always_ff @(posedge clk)
  begin
    frm_s1_q <= frame_tgl;
    frm_s2_q <= frm_s1_q;
    if (reset)
    begin
      frm_last_q <= 1'b0;
      ack_tgl_q <= 1'b0;
      extract_hold_q <= '0;
      ohd_insert_bytes <= '0;
      ohd_insert_valid <= 1'b0;
      rx_overhead_frame_pulse <= 1'b0;
    end
    else
    begin
      frm_last_q <= frm_s2_q;
      ohd_insert_valid <= 1'b0;
      if (frm_s2_q != frm_last_q && link_run_q)
      begin
        ohd_insert_bytes <= insert_cap; // RULE9
        ohd_insert_valid <= 1'b1; // RULE3
        for (int ch = 0; ch < NUM_CH; ch++)
          extract_hold_q[ch] <= cfg.overhead_enable[ch] ? ohd_extract_bytes[ch] : scop_pkg::RESET_BYTE;
        ack_tgl_q <= ~ack_tgl_q;
      end
      rx_overhead_frame_pulse <= (frm_s2_q != frm_last_q) && link_run_q; // RULE6
    end
  end

  scop_ohd_link u_link (
    .link_clk(overhead_processor_clock),
    .reset_level(reset_q),
    .run_level(link_run_q),
    .ack_tgl(ack_tgl_q),
    .extract_hold(extract_hold_q),
    .insert_in(overhead_serial_insert_in),
    .serial_out(overhead_serial_out),
    .frame_pulse(),
    .frame_tgl(frame_tgl),
    .insert_cap(insert_cap)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_oe_mirror: assert property (##1 rx_output_enable_status == $past(cfg.output_enable)) // RULE10
    else $error("output enable status not mirrored");
  a_ohd_mirror: assert property (##1 overhead_channel_enable_status == $past(cfg.overhead_enable)) // RULE11
    else $error("overhead enable status not mirrored");
  a_ck_en_flag: assert property (cfg.clk_fp_enable |=> rx_overhead_clock_enable_flag) // RULE5
    else $error("clock enable flag not set");
  a_link_active: assert property (overhead_link_clock_active |-> $past(cfg.serial_mode, 2)) // RULE7
    else $error("link active outside serial mode");
  a_frame_width: assert property (rx_overhead_frame_pulse |=> !rx_overhead_frame_pulse) // RULE6
    else $error("frame pulse wider than one cycle");
  a_rclk_period: assert property ($rose(recovered_channel_clock[0]) |-> ##4 $rose(recovered_channel_clock[0])) // RULE1
    else $error("recovered clock period wrong");
  a_rx_timed: assert property ($changed(rx_data_out[0]) |-> $rose(recovered_channel_clock[0])) // RULE2
    else $error("receive data not timed by recovered clock");
  a_sel_filter: assert property ((sel_raw[0] == 1'b1) [*4] |=> pair_protect_active[0]) // RULE15
    else $error("protect select not taken");
  a_insert_mode: assert property (ohd_insert_valid |-> overhead_link_clock_active) // RULE3
    else $error("insert data outside serial mode");

  c_protect_switch: cover property ($rose(serial_protect_active[7]));
  c_insert_word: cover property (ohd_insert_valid);
  c_rx_byte: cover property (rx_data_out[0].valid);
endmodule : scop_core

// ---- sim/scop_fabric_model.sv ----
// Fabric-side model: link clock, transmit overhead enable and insert bits
`timescale 1ns/100ps
module scop_fabric_model (
  input wire logic run,
  output logic overhead_processor_clock,
  output logic tx_overhead_clock_enable,
  output logic [scop_pkg::NUM_CH-1:0] overhead_serial_insert_in
);
  // Free-running link clock, unrelated in phase to clk
  initial
  begin
    overhead_processor_clock = 1'b0;
    #37;
    forever #80 overhead_processor_clock = ~overhead_processor_clock;
  end

  assign tx_overhead_clock_enable = run;

  // Odd channels insert all ones, even channels all zeros
  always @(negedge overhead_processor_clock)
    overhead_serial_insert_in <= run ? 8'haa : 8'h00;
endmodule : scop_fabric_model

// ---- sim/scop_core_bench.sv ----
// Self-checking bench for the overhead, status and protection port block
`timescale 1ns/100ps
module scop_core_bench;
  logic clk, reset, run, lclk, tx_en, ck_flag, link_act, fp, ins_valid, p_fp;
  scop_pkg::scop_cfg_type cfg;
  logic [11:0] sel, p_sel;
  logic [16:0] p_stat;
  scop_pkg::scop_rx_byte_type [7:0] rx_word, rx_out;
  scop_pkg::scop_rx_byte_type p_rx;
  scop_pkg::scop_ohd_bytes_type extract, ins_bytes;
  logic [7:0] ins, rclk, oe_st, ohe_st, sout, ser_act, b, pr;
  logic [3:0] pair_act;
  logic [15:0] w;
  int bad_count, compares, cycles, seed, n, fp_n, ok;
  logic [16:0] q_stat[$];
  logic [11:0] q_sel[$];
  logic [7:0] q_rx[$];
  logic [63:0] q_ins[$];

  scop_core dut (.clk(clk), .reset(reset), .cfg(cfg), .tx_overhead_clock_enable(tx_en),
    .pair_protect_select_first(sel[8]), .pair_protect_select_second(sel[9]),
    .pair_protect_select_third(sel[10]), .pair_protect_select_fourth(sel[11]),
    .serial_protect_select_ch0(sel[0]), .serial_protect_select_ch1(sel[1]),
    .serial_protect_select_ch2(sel[2]), .serial_protect_select_ch3(sel[3]),
    .serial_protect_select_ch4(sel[4]), .serial_protect_select_ch5(sel[5]),
    .serial_protect_select_ch6(sel[6]), .serial_protect_select_ch7(sel[7]),
    .rx_word(rx_word), .ohd_extract_bytes(extract), .overhead_processor_clock(lclk),
    .overhead_serial_insert_in(ins), .recovered_channel_clock(rclk), .rx_data_out(rx_out),
    .rx_output_enable_status(oe_st), .overhead_channel_enable_status(ohe_st),
    .rx_overhead_clock_enable_flag(ck_flag), .overhead_link_clock_active(link_act),
    .rx_overhead_frame_pulse(fp), .overhead_serial_out(sout), .ohd_insert_bytes(ins_bytes),
    .ohd_insert_valid(ins_valid), .pair_protect_active(pair_act), .serial_protect_active(ser_act));

  scop_fabric_model fabric (.run(run), .overhead_processor_clock(lclk),
    .tx_overhead_clock_enable(tx_en), .overhead_serial_insert_in(ins));

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #10;
  endtask : tick

  task automatic give_verdict;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Watcher: each change of a result takes the oldest note
  always @(posedge clk)
  begin
    #1;
    cycles++;
    if (cycles == 2000)
    begin
      bad_count++;
      give_verdict();
    end
    if (!reset)
    begin
      if ({ck_flag, oe_st, ohe_st} !== p_stat)
        chk("status", q_stat.size() ? q_stat.pop_front() : 'x, {ck_flag, oe_st, ohe_st});
      if ({pair_act, ser_act} !== p_sel)
        chk("protect", q_sel.size() ? q_sel.pop_front() : 'x, {pair_act, ser_act});
      if (rx_out[0].valid && rx_out[0] !== p_rx)
      begin
        chk("rx_data", q_rx.size() ? q_rx.pop_front() : 'x, rx_out[0].data);
        chk("rx_edge", 1, rclk[0]);
      end
      if (fp && p_fp)
        chk("fp_width", 0, 1);
      if (fp && !p_fp)
        fp_n++;
      if (ins_valid)
      begin
        chk("fp_with_insert", 1, fp);
        if (q_ins.size())
          chk("insert", q_ins.pop_front(), ins_bytes);
      end
    end
    p_stat = {ck_flag, oe_st, ohe_st};
    p_sel = {pair_act, ser_act};
    p_rx = rx_out[0];
    p_fp = fp;
  end

  initial
  begin
    seed = 47235;
    reset = 1'b1;
    cfg = '0;
    sel = '0;
    rx_word = '0;
    extract = '0;
    run = 1'b0;
    tick(8);
    reset = 1'b0;
    tick(6);
    repeat (8)
    begin
      cfg = cfg ^ (18'($random(seed)) | 18'h00400);
      cfg.serial_mode = 1'b0;
      q_stat.push_back({cfg.clk_fp_enable, cfg.output_enable, cfg.overhead_enable});
      tick(3);
    end
    repeat (8)
    begin
      sel = sel ^ (12'($random(seed)) | 12'h001);
      q_sel.push_back(sel);
      tick(6);
    end
    // One-cycle glitch must not pass the filter
    sel = ~sel;
    tick(1);
    sel = ~sel;
    tick(8);
    cfg = {8'hff, 8'hff, 1'b0, 1'b1};
    q_stat.push_back({1'b1, 8'hff, 8'hff});
    tick(3);
    repeat (6)
    begin
      rx_word[0] = {8'($random(seed)), 1'b1};
      q_rx.push_back(rx_word[0].data);
      tick(1);
      rx_word[0].valid = 1'b0;
      tick(11);
    end
    // Disabled channel shows no data
    cfg.output_enable[0] = 1'b0;
    q_stat.push_back({1'b1, 8'hfe, 8'hff});
    rx_word[0] = {8'h5a, 1'b1};
    tick(1);
    rx_word[0].valid = 1'b0;
    tick(11);
    chk("rx_gated", 0, rx_out[0]);
    cfg.output_enable[0] = 1'b1;
    q_stat.push_back({1'b1, 8'hff, 8'hff});
    tick(3);
    n = 0;
    repeat (40)
    begin
      pr = rclk;
      tick(1);
      chk("rclk_phase", {8{rclk[0]}}, rclk);
      if (rclk[0] && !pr[0])
        n++;
    end
    chk("rclk_rises", 10, n);
    chk("no_frames", 0, fp_n);
    chk("idle_out", 0, sout);
    for (int i = 0; i < 8; i++)
      extract[i] = 8'($random(seed));
    cfg.serial_mode = 1'b1;
    run = 1'b1;
    tick(80);
    chk("link_active", 1, link_act);
    repeat (3) q_ins.push_back(64'hff00ff00ff00ff00);
    for (n = 0; n < 100 && q_ins.size() > 0; n++)
      tick(1);
    chk("insert_drain", 0, q_ins.size());
    repeat (8)
    begin
      @(posedge lclk);
      #5;
      b = {b[6:0], sout[0]};
    end
    ok = 0;
    for (n = 0; n < 8; n++)
    begin
      w = {b, b} >> n;
      if (w[7:0] === extract[0])
        ok = 1;
    end
    chk("serial_out", 1, ok);
    chk("frames_seen", 1, fp_n > 3);
    tick(1);
    cfg.serial_mode = 1'b0;
    run = 1'b0;
    tick(40);
    n = fp_n;
    tick(40);
    chk("stopped", n, fp_n);
    chk("stop_out", 0, sout);
    chk("link_idle", 0, link_act);
    give_verdict();
  end
endmodule : scop_core_bench
